/* File: include/ccr_map.vh */
// Constants for the comparator configuration register block.
// Assumes an 8-bit special-function-register access port on the core side.
`ifndef CCR_MAP_VH
`define CCR_MAP_VH

// Register addresses within the special-function space
`define CCR_MODE_ADDR 8'h9D
`define CCR_INSEL_ADDR 8'h9F

// Reset values
`define CCR_MODE_RESET 8'h02
`define CCR_INSEL_RESET 8'hFF

// Writable bit masks; other mode bits read as zero, other input-select bits read as one
`define CCR_MODE_MASK 8'h33
`define CCR_INSEL_MASK 8'h33

// Field positions in the mode-control register
`define CCR_RISE_IE_BIT 5
`define CCR_FALL_IE_BIT 4
`define CCR_RESP_LSB 0

// Field positions in the input-select register
`define CCR_NEG_LSB 4
`define CCR_POS_LSB 0

// Flag bit positions in the edge-flag clear word
`define CCR_RISE_FLAG_BIT 5
`define CCR_FALL_FLAG_BIT 4

// Typical response times in nanoseconds, one per mode code
`define CCR_RESP_NS_0 100
`define CCR_RESP_NS_1 175
`define CCR_RESP_NS_2 320
`define CCR_RESP_NS_3 1050

// Clock period in nanoseconds
`define CCR_CLK_NS 8

`endif

/* File: verilog/ccr_edge_flags.v */
// Edge detector and sticky edge flags for the comparator output.
// Assumes the comparator output is asynchronous; it is synchronised here.
`timescale 1ns/100ps
`default_nettype none

module ccr_edge_flags (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Raw comparator output
    input wire cmp_out,
    // Software clear strobes
    input wire clr_rise,
    input wire clr_fall,
    // Sticky flags
    output reg rise_flag_q,
    output reg fall_flag_q
);

    reg sync1_q; // First synchroniser stage
    reg sync2_q; // Second synchroniser stage
    reg prev_q; // Previous synchronised level
    wire rise_ev; // Rising transition seen
    wire fall_ev; // Falling transition seen

    // Two-stage synchroniser plus delayed copy for edge detection
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= cmp_out;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign rise_ev = sync2_q & ~prev_q;
    assign fall_ev = ~sync2_q & prev_q;

    // Sticky flags; a new edge wins over a same-cycle clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            rise_flag_q <= 1'b0;
            fall_flag_q <= 1'b0;
        end else begin
            if (rise_ev) begin
                rise_flag_q <= 1'b1;
            end else if (clr_rise) begin
                rise_flag_q <= 1'b0;
            end
            if (fall_ev) begin
                fall_flag_q <= 1'b1;
            end else if (clr_fall) begin
                fall_flag_q <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* File: verilog/ccr_top.v */
// Comparator configuration registers: mode control and input select.
// Assumes a single-cycle SFR port from the core on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "ccr_map.vh"

module ccr_top (
    // Clock and reset
    input wire CLOCK,
    input wire RESET,
    // SFR access port
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_WR,
    input wire SFR_RD,
    output reg [7:0] SFR_RDATA,
    // Edge-flag clear port from the control register
    input wire [7:0] FLAG_CLR,
    // Comparator interface
    input wire CMP_OUT,
    output reg [1:0] RESP_MODE,
    output reg [1:0] NEG_SEL,
    output reg [1:0] POS_SEL,
    output reg [15:0] RESP_CYCLES,
    // Flags and interrupt requests
    output reg RISE_FLAG,
    output reg FALL_FLAG,
    output reg RISE_IRQ,
    output reg FALL_IRQ
);

    // Response times converted to cycles, rounded down, with no minimum applied
    localparam [15:0] RESP_CYC_0 = `CCR_RESP_NS_0 / `CCR_CLK_NS;
    localparam [15:0] RESP_CYC_1 = `CCR_RESP_NS_1 / `CCR_CLK_NS;
    localparam [15:0] RESP_CYC_2 = `CCR_RESP_NS_2 / `CCR_CLK_NS;
    localparam [15:0] RESP_CYC_3 = `CCR_RESP_NS_3 / `CCR_CLK_NS;

    reg [7:0] mode_q; // Mode-control storage
    reg [7:0] insel_q; // Input-select storage
    wire rise_flag; // Sticky rising flag
    wire fall_flag; // Sticky falling flag
    reg [7:0] rdata_d; // Read mux result
    reg [15:0] cyc_d; // Response cycles for current mode

    // Address match helper
    function hit;
        input [7:0] a;
        input [7:0] b;
        begin
            hit = (a == b);
        end
    endfunction

    // Register writes; only implemented bits are stored
    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            mode_q <= `CCR_MODE_RESET;
            insel_q <= `CCR_INSEL_RESET;
        end else if (SFR_WR) begin
            if (hit(SFR_ADDR, `CCR_MODE_ADDR)) begin
                mode_q <= SFR_WDATA & `CCR_MODE_MASK;
            end
            if (hit(SFR_ADDR, `CCR_INSEL_ADDR)) begin
                insel_q <= SFR_WDATA & `CCR_INSEL_MASK;
            end
        end
    end

    // Read mux; unimplemented mode bits come back zero, unimplemented input-select bits come back one
    always @* begin
        rdata_d = 8'h00;
        if (hit(SFR_ADDR, `CCR_MODE_ADDR)) begin
            rdata_d = mode_q & `CCR_MODE_MASK;
        end else if (hit(SFR_ADDR, `CCR_INSEL_ADDR)) begin
            // Unused select bits always read back as ones, whatever was written
            rdata_d = insel_q | ~`CCR_INSEL_MASK;
        end
    end

    // Response-time lookup for the selected mode
    always @* begin
        case (mode_q[`CCR_RESP_LSB +: 2])
            2'h0: cyc_d = RESP_CYC_0;
            2'h1: cyc_d = RESP_CYC_1;
            2'h2: cyc_d = RESP_CYC_2;
            default: cyc_d = RESP_CYC_3;
        endcase
    end

    // Sticky edge flags
    ccr_edge_flags u_flags (
        .clk(CLOCK),
        .rst(RESET),
        .cmp_out(CMP_OUT),
        .clr_rise(FLAG_CLR[`CCR_RISE_FLAG_BIT]),
        .clr_fall(FLAG_CLR[`CCR_FALL_FLAG_BIT]),
        .rise_flag_q(rise_flag),
        .fall_flag_q(fall_flag)
    );

    // Registered outputs
    always @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            SFR_RDATA <= 8'h00;
            RESP_MODE <= 2'h2;
            NEG_SEL <= 2'h3;
            POS_SEL <= 2'h3;
            RESP_CYCLES <= RESP_CYC_2;
            RISE_FLAG <= 1'b0;
            FALL_FLAG <= 1'b0;
            RISE_IRQ <= 1'b0;
            FALL_IRQ <= 1'b0;
        end else begin
            SFR_RDATA <= SFR_RD ? rdata_d : 8'h00;
            RESP_MODE <= mode_q[`CCR_RESP_LSB +: 2];
            NEG_SEL <= insel_q[`CCR_NEG_LSB +: 2];
            POS_SEL <= insel_q[`CCR_POS_LSB +: 2];
            RESP_CYCLES <= cyc_d;
            RISE_FLAG <= rise_flag;
            FALL_FLAG <= fall_flag;
            RISE_IRQ <= rise_flag & mode_q[`CCR_RISE_IE_BIT];
            FALL_IRQ <= fall_flag & mode_q[`CCR_FALL_IE_BIT];
        end
    end

endmodule

`default_nettype wire

/* File: verification/ccr_checker.sv */
// Port-level checks for the comparator register block.
// Bound into ccr_top; one clock domain, async reset.
`timescale 1ns/100ps
`default_nettype none
module ccr_checker (
    // Clock, reset and register port
    input wire CLOCK, input wire RESET, input wire SFR_WR, input wire SFR_RD,
    input wire [7:0] SFR_ADDR, input wire [7:0] SFR_WDATA,
    input wire [7:0] SFR_RDATA, input wire [7:0] FLAG_CLR,
    // Comparator side
    input wire CMP_OUT, input wire [1:0] RESP_MODE, input wire [1:0] NEG_SEL,
    input wire [1:0] POS_SEL, input wire [15:0] RESP_CYCLES,
    input wire RISE_FLAG, input wire FALL_FLAG, input wire RISE_IRQ,
    input wire FALL_IRQ
);
    // Response cycles per mode code, code 0 lowest
    wire [63:0] tab = 64'h0083_0028_0015_000C;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);
    a_hi: assert property (SFR_RD && SFR_ADDR == 8'h9D |=>
        SFR_RDATA[7:6] == 2'h0) else $error("mode high bits");
    a_mid: assert property (SFR_RD && SFR_ADDR == 8'h9D |=>
        SFR_RDATA[3:2] == 2'h0) else $error("mode mid bits");
    a_rie: assert property (RISE_IRQ |-> RISE_FLAG)
        else $error("rise request without flag");
    a_fie: assert property (FALL_IRQ |-> FALL_FLAG)
        else $error("fall request without flag");
    a_tab: assert property (RESP_CYCLES == tab[RESP_MODE*16 +: 16])
        else $error("response cycles");
    a_sel: assert property (SFR_WR && SFR_ADDR == 8'h9F |-> ##2
        NEG_SEL == $past(SFR_WDATA[5:4], 2)) else $error("neg select");
    a_set: assert property ($rose(CMP_OUT) ##1 CMP_OUT [*3] |->
        ##[0:2] RISE_FLAG) else $error("rise flag not set");
    a_hold: assert property (RISE_FLAG && !FLAG_CLR[5] &&
        !$past(FLAG_CLR[5]) |=> RISE_FLAG) else $error("flag dropped");
endmodule
bind ccr_top ccr_checker chk (.*);
`default_nettype wire

/* File: verification/ccr_top_bench.sv */
// Self-checking bench for the comparator register block.
// Drives all inputs at the falling clock edge.
`timescale 1ns/100ps
`default_nettype none
module ccr_top_bench;
    // Stimulus and observed signals
    logic CLOCK = 0, RESET = 1, SFR_WR = 0, SFR_RD = 0, CMP_OUT = 0, pend = 0;
    logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, FLAG_CLR = 0, SFR_RDATA, w;
    logic [1:0] RESP_MODE, NEG_SEL, POS_SEL;
    logic [15:0] RESP_CYCLES, cyc [4] = '{16'h000C, 16'h0015, 16'h0028, 16'h0083};
    logic RISE_FLAG, FALL_FLAG, RISE_IRQ, FALL_IRQ;
    logic [7:0] expq [$];
    int failures = 0, n_checks = 0;
    ccr_top uut (.*);
    initial forever #4 CLOCK = ~CLOCK;
    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        SFR_ADDR = a;
        SFR_WDATA = d;
        SFR_WR = 1;
        @(negedge CLOCK) SFR_WR = 0;
    endtask
    // Read request; expected data is queued for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expq.push_back(e);
        SFR_ADDR = a;
        SFR_RD = 1;
        @(negedge CLOCK) SFR_RD = 0;
    endtask
    task automatic conclude;
        if (failures == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Read data is valid in the cycle after the read edge
    always @(posedge CLOCK) pend <= SFR_RD;
    always @(negedge CLOCK) if (pend) chk(expq.pop_front(), SFR_RDATA);
    initial begin
        w = $urandom(32'h66C2);
        repeat (3) @(negedge CLOCK);
        RESET = 0;
        rd(8'h9D, 8'h02);
        rd(8'h9F, 8'hFF);
        chk(16'h0028, RESP_CYCLES);
        repeat (8) begin
            w = $urandom;
            wr(8'h9D, w);
            rd(8'h9D, w & 8'h33);
            @(negedge CLOCK);
            chk(cyc[w[1:0]], RESP_CYCLES);
            chk(w[1:0], RESP_MODE);
            w = $urandom;
            wr(8'h9F, w);
            rd(8'h9F, w | 8'hCC);
            @(negedge CLOCK);
            chk({w[5:4], w[1:0]}, {NEG_SEL, POS_SEL});
        end
        wr(8'h9E, 8'hFF);
        rd(8'h9E, 8'h00);
        wr(8'h9D, 8'h30);
        CMP_OUT = 1;
        repeat (6) @(negedge CLOCK);
        chk(2'h3, {RISE_FLAG, RISE_IRQ});
        CMP_OUT = 0;
        repeat (6) @(negedge CLOCK);
        chk(3'h7, {RISE_FLAG, FALL_FLAG, FALL_IRQ});
        wr(8'h9D, 8'h00);
        repeat (3) @(negedge CLOCK);
        chk(4'hC, {RISE_FLAG, FALL_FLAG, RISE_IRQ, FALL_IRQ});
        FLAG_CLR = 8'h30;
        @(negedge CLOCK) FLAG_CLR = 8'h00;
        repeat (3) @(negedge CLOCK);
        chk(2'h0, {RISE_FLAG, FALL_FLAG});
        conclude;
    end
    // Hang guard at 2000 cycles, far beyond the roughly 80 cycles needed
    initial begin
        #(8 * 2000);
        failures++;
        conclude;
    end
endmodule
`default_nettype wire
